// [design/hub_cfg_regs.sv]
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "hub_cfg_params.svh"
// Functional notes
// - eight-bit wake threshold, 4 mg per count
// - temperature bytes pushed each sample when enabled
// - per-axis rate bytes pushed when enabled
// - pushes continue despite sensing path standby
// - all six accel bytes pushed when enabled
// - targets 2,1,0 external bytes pushed when enabled
// - target 3 enable lives in master control
// - multi-controller off: clock gating, no arbitration
// - data ready waits for external bytes
// - stop-then-start or repeated start between reads
// - bit 7 picks target 0 read/write
// - low seven bits: target 0 bus address
// - target 0 start register address byte
module hub_cfg_regs
    import hub_cfg_pkg::*;
#(
    parameter int ADDR_W = 12              // byte address width
)(
    input  wire logic              clk_sys_i,
    input  wire logic              resetn_i,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // neighbouring units
    input  wire logic              sample_tick_i,    // one per sample
    input  wire logic              aux_if_enabled_i, // aux master on
    input  wire logic              aux_idle_i,       // aux master idle
    input  wire logic              ext_loaded_i,     // ext bytes loaded
    input  wire logic              arb_lost_i,       // arbitration lost
    output logic [8:0]             fifo_push_o,      // per-source push
    output logic [7:0]             motion_wake_level_o,
    output logic                   aux_clk_gate_en_o,
    output logic                   arb_detect_en_o,
    output logic                   stop_between_reads_o,
    output logic [3:0]             aux_bus_clk_div_o,
    output logic                   target0_read_not_write_o,
    output logic [6:0]             target0_bus_addr_o,
    output logic [7:0]             target0_start_reg_o,
    output logic                   data_ready_o,     // one-cycle pulse
    output logic                   irq_o             // level
);
    // ------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] aw_addr_r;      // held write address
    logic              aw_held_r;      // address taken, not yet used
    logic [7:0]        w_data_r;       // held low byte
    logic              w_strb_r;       // low lane enabled
    logic              w_held_r;       // data taken, not yet used
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    logic              wr_go;          // both halves present
    logic [9:0]        wr_idx;
    logic [9:0]        rd_idx;
    logic              wr_hit;
    logic [31:0]       rd_word;
    logic              rd_hit;

    // both channels are single-entry, so a second request waits
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign wr_go  = aw_held_r && w_held_r && !bvalid_r;
    assign wr_idx = aw_addr_r[ADDR_W-1:2];
    assign rd_idx = s_axi_araddr[ADDR_W-1:2];

    // write address capture
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    // write data capture, only the low byte is meaningful
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            w_held_r <= 1'b0;
            w_data_r <= `CFG_RESET;
            w_strb_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_strb_r <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    // write response, decode error for unmapped words
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    cfg_byte_t wake_q;
    cfg_byte_t fifo_q;
    cfg_byte_t mctl_q;
    cfg_byte_t t0addr_q;
    cfg_byte_t t0reg_q;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_en_r;
    logic       wr_ok;                // write with low lane enabled

    assign wr_ok = wr_go && w_strb_r;

    // which word a pending write lands on
    always_comb begin
        unique case (wr_idx)
            `IDX_WAKE, `IDX_FIFO, `IDX_MCTL, `IDX_T0ADDR,
            `IDX_T0REG, `IDX_IRQ_STAT, `IDX_IRQ_EN,
            `IDX_IRQ_CLR: wr_hit = 1'b1;
            default:      wr_hit = 1'b0;   // unmapped
        endcase
    end

    cfg_reg8 u_wake (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .wr_i      (wr_ok && wr_idx == `IDX_WAKE),
        .wdata_i   (w_data_r),
        .q_o       (wake_q)
    );
    cfg_reg8 u_fifo (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .wr_i      (wr_ok && wr_idx == `IDX_FIFO),
        .wdata_i   (w_data_r),
        .q_o       (fifo_q)
    );
    cfg_reg8 u_mctl (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .wr_i      (wr_ok && wr_idx == `IDX_MCTL),
        .wdata_i   (w_data_r),
        .q_o       (mctl_q)
    );
    cfg_reg8 u_t0addr (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .wr_i      (wr_ok && wr_idx == `IDX_T0ADDR),
        .wdata_i   (w_data_r),
        .q_o       (t0addr_q)
    );
    cfg_reg8 u_t0reg (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .wr_i      (wr_ok && wr_idx == `IDX_T0REG),
        .wdata_i   (w_data_r),
        .q_o       (t0reg_q)
    );

    // settings straight out to the neighbours
    assign motion_wake_level_o = wake_q;
    assign stop_between_reads_o = mctl_q[`MCTL_STOP];
    assign aux_bus_clk_div_o =
        mctl_q[`MCTL_DIV_HI:`MCTL_DIV_LO];
    assign target0_read_not_write_o = t0addr_q[`TADDR_RNW];
    assign target0_bus_addr_o = t0addr_q[`TADDR_ID_HI:0];
    assign target0_start_reg_o = t0reg_q;
    // gating only allowed when single-controller and idle
    assign aux_clk_gate_en_o =
        !mctl_q[`MCTL_MULTI] && aux_idle_i;
    assign arb_detect_en_o = mctl_q[`MCTL_MULTI];

    // ------------------------------------------------------------
    // fifo push requests
    // ------------------------------------------------------------
    // standby of a sensing path is deliberately not an input here:
    // an enabled source keeps buffering regardless
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fifo_push_o <= '0;
        end else if (sample_tick_i) begin
            fifo_push_o <= {mctl_q[`MCTL_T3],
                            fifo_q[`FEN_T2], fifo_q[`FEN_T1],
                            fifo_q[`FEN_T0],
                            fifo_q[`FEN_ACCEL],
                            fifo_q[`FEN_RATE_Z],
                            fifo_q[`FEN_RATE_Y],
                            fifo_q[`FEN_RATE_X],
                            fifo_q[`FEN_TEMP]};
        end else begin
            fifo_push_o <= '0;
        end
    end

    // ------------------------------------------------------------
    // data-ready sequencing
    // ------------------------------------------------------------
    drdy_state_t drdy_st_r;
    logic        hold_off;            // must wait for ext bytes

    // a disabled aux master never loads, so never wait on it
    assign hold_off = mctl_q[`MCTL_WAIT] && aux_if_enabled_i;

    // waiting state
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            drdy_st_r <= drdy_idle;
        end else begin
            unique case (drdy_st_r)
                drdy_idle: begin
                    if (sample_tick_i && hold_off) begin
                        drdy_st_r <= drdy_wait;
                    end
                end
                drdy_wait: begin
                    if (ext_loaded_i || !aux_if_enabled_i) begin
                        drdy_st_r <= drdy_idle;
                    end
                end
            endcase
        end
    end

    // ready pulse, one cycle
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_ready_o <= 1'b0;
        end else if (drdy_st_r == drdy_idle) begin
            data_ready_o <= sample_tick_i && !hold_off;
        end else begin
            data_ready_o <= ext_loaded_i || !aux_if_enabled_i;
        end
    end

    // ------------------------------------------------------------
    // interrupt status, enable and clear
    // ------------------------------------------------------------
    logic [1:0] irq_set;
    logic [1:0] irq_clr;

    assign irq_set[`IRQ_DRDY] = data_ready_o;
    // arbitration loss only counts while detection is on
    assign irq_set[`IRQ_ARB] = arb_lost_i && arb_detect_en_o;
    assign irq_clr = (wr_ok && wr_idx == `IDX_IRQ_CLR) ?
                     w_data_r[1:0] : `IRQ_RESET;

    // sticky status; a set in the clear cycle wins
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_stat_r <= `IRQ_RESET;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    // enable mask
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_en_r <= `IRQ_RESET;
        end else if (wr_ok && wr_idx == `IDX_IRQ_EN) begin
            irq_en_r <= w_data_r[1:0];
        end
    end

    assign irq_o = |(irq_stat_r & irq_en_r);

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        unique case (rd_idx)
            `IDX_WAKE:     rd_word[7:0] = wake_q;
            `IDX_FIFO:     rd_word[7:0] = fifo_q;
            `IDX_MCTL:     rd_word[7:0] = mctl_q;
            `IDX_T0ADDR:   rd_word[7:0] = t0addr_q;
            `IDX_T0REG:    rd_word[7:0] = t0reg_q;
            `IDX_IRQ_STAT: rd_word[1:0] = irq_stat_r;
            `IDX_IRQ_EN:   rd_word[1:0] = irq_en_r;
            `IDX_IRQ_CLR:  rd_word[1:0] = `IRQ_RESET;  // write-only
            default:       rd_hit = 1'b0;
        endcase
    end

    // read data, registered one cycle after the address
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    wake_level_a: assert property (
        wr_ok && wr_idx == `IDX_WAKE |=>
            motion_wake_level_o == $past(w_data_r))
        else $error("wake threshold not stored");
    temp_push_a: assert property (
        sample_tick_i |=> fifo_push_o[0] == $past(fifo_q[`FEN_TEMP]))
        else $error("temperature push wrong");
    rate_push_a: assert property (
        sample_tick_i |=> fifo_push_o[3:1] ==
            {$past(fifo_q[`FEN_RATE_Z]), $past(fifo_q[`FEN_RATE_Y]),
             $past(fifo_q[`FEN_RATE_X])})
        else $error("rate axis push wrong");
    push_idle_a: assert property (
        !sample_tick_i |=> fifo_push_o == '0)
        else $error("push outside sample tick");
    accel_push_a: assert property (
        sample_tick_i && fifo_q[`FEN_ACCEL] |=> fifo_push_o[4])
        else $error("accel push missing");
    target_push_a: assert property (
        sample_tick_i |=> fifo_push_o[7:5] == $past(fifo_q[2:0]))
        else $error("target push wrong");
    target3_push_a: assert property (
        sample_tick_i |=> fifo_push_o[8] == $past(mctl_q[`MCTL_T3]))
        else $error("target 3 push wrong");
    arb_gate_a: assert property (
        !arb_detect_en_o |=> !irq_stat_r[`IRQ_ARB] ||
            $past(irq_stat_r[`IRQ_ARB]))
        else $error("arbitration event while disabled");
    drdy_hold_a: assert property (
        drdy_st_r == drdy_wait && !ext_loaded_i && aux_if_enabled_i
            |=> !data_ready_o)
        else $error("data ready not held off");
    drdy_free_a: assert property (
        drdy_st_r == drdy_idle && sample_tick_i && !hold_off
            |=> data_ready_o ##1 (!data_ready_o || $past(sample_tick_i)))
        else $error("data ready missing");
    stop_reads_a: assert property (
        wr_ok && wr_idx == `IDX_MCTL |=>
            stop_between_reads_o == $past(w_data_r[`MCTL_STOP]) &&
            aux_bus_clk_div_o ==
                $past(w_data_r[`MCTL_DIV_HI:`MCTL_DIV_LO]))
        else $error("master control fields wrong");
    target0_addr_a: assert property (
        wr_ok && wr_idx == `IDX_T0ADDR |=>
            target0_read_not_write_o == $past(w_data_r[7]) &&
            target0_bus_addr_o == $past(w_data_r[6:0]))
        else $error("target 0 address wrong");
    start_reg_a: assert property (
        wr_ok && wr_idx == `IDX_T0REG |=>
            target0_start_reg_o == $past(w_data_r))
        else $error("start register wrong");
endmodule

// [design/hub_cfg_params.svh]
`ifndef HUB_CFG_PARAMS_SVH
`define HUB_CFG_PARAMS_SVH
// ----------------------------------------------------------------
// register indexes (byte address = index * 4)
// ----------------------------------------------------------------
`define IDX_WAKE      10'h01f
`define IDX_FIFO      10'h023
`define IDX_MCTL      10'h024
`define IDX_T0ADDR    10'h025
`define IDX_T0REG     10'h026
`define IDX_IRQ_STAT  10'h040
`define IDX_IRQ_EN    10'h041
`define IDX_IRQ_CLR   10'h042
// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define CFG_RESET     8'h00
`define IRQ_RESET     2'h0
`define FEN_TEMP      7
`define FEN_RATE_X    6
`define FEN_RATE_Y    5
`define FEN_RATE_Z    4
`define FEN_ACCEL     3
`define FEN_T2        2
`define FEN_T1        1
`define FEN_T0        0
`define MCTL_MULTI    7
`define MCTL_WAIT     6
`define MCTL_T3       5
`define MCTL_STOP     4
`define MCTL_DIV_HI   3
`define MCTL_DIV_LO   0
`define TADDR_RNW     7
`define TADDR_ID_HI   6
`define IRQ_DRDY      0
`define IRQ_ARB       1
// ----------------------------------------------------------------
// bus response codes
// ----------------------------------------------------------------
`define RESP_OKAY     2'h0
`define RESP_DECERR   2'h3
`endif

// [design/hub_cfg_pkg.sv]
package hub_cfg_pkg;
    // data-ready sequencing while external bytes are pending
    typedef enum logic {
        drdy_idle,
        drdy_wait
    } drdy_state_t;
    typedef logic [7:0] cfg_byte_t;   // one configuration register
endpackage

// [design/cfg_reg8.sv]
`timescale 1ns/1ps
`include "hub_cfg_params.svh"
// ----------------------------------------------------------------
// one software-writable configuration byte
// ----------------------------------------------------------------
module cfg_reg8
    import hub_cfg_pkg::*;
(
    input  wire logic      clk_sys_i,   // system clock
    input  wire logic      resetn_i,    // async reset, active low
    input  wire logic      wr_i,        // write strobe, low lane enabled
    input  wire logic [7:0] wdata_i,    // write data, low byte
    output cfg_byte_t      q_o          // stored value
);
    // stored value, cleared on reset
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_o <= `CFG_RESET;
        end else if (wr_i) begin
            q_o <= wdata_i;
        end
    end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
`include "hub_cfg_params.svh"
// ----------------------------------------------------------------
// self-checking bench for the sensor hub configuration bank
// ----------------------------------------------------------------
module testbench
    import hub_cfg_pkg::*;
;
    logic        clk_sys_i, resetn_i;           // clock, reset
    logic [11:0] s_axi_awaddr, s_axi_araddr;    // byte addresses
    logic        s_axi_awvalid, s_axi_awready;  // write address
    logic [31:0] s_axi_wdata, s_axi_rdata;      // data words
    logic [3:0]  s_axi_wstrb;                   // low lane only used
    logic        s_axi_wvalid, s_axi_wready;    // write data
    logic [1:0]  s_axi_bresp, s_axi_rresp;      // responses
    logic        s_axi_bvalid, s_axi_bready;    // write response
    logic        s_axi_arvalid, s_axi_arready;  // read address
    logic        s_axi_rvalid, s_axi_rready;    // read data
    logic        sample_tick_i, aux_if_enabled_i, aux_idle_i;
    logic        ext_loaded_i, arb_lost_i;      // event pulses
    logic [8:0]  fifo_push_o, p;                // pushes, sampled copy
    logic [7:0]  motion_wake_level_o, target0_start_reg_o;
    logic        aux_clk_gate_en_o, arb_detect_en_o;
    logic        stop_between_reads_o, target0_read_not_write_o;
    logic [3:0]  aux_bus_clk_div_o;
    logic [6:0]  target0_bus_addr_o;
    logic        data_ready_o, irq_o, d;        // d: sampled ready
    int          n_mismatch, total_checks, cycles;
    // one table row: register, word written, word read back
    typedef struct packed {
        logic [9:0]  idx;
        logic [31:0] wval;
        logic [31:0] rval;
    } row_t;
    row_t        rows [12];

    hub_cfg_regs #(.ADDR_W(12)) dut (.*);

    // 20 MHz clock
    always #25 clk_sys_i = ~clk_sys_i;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [11:0] ba(input logic [9:0] i);
        return {i, 2'h0};                       // one word per index
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // handshake decided at negedge: inputs only move at posedge
    task automatic wr(input logic [9:0] i, input logic [31:0] v,
                      input logic [1:0] er);
        logic at, wt, bt;
        logic [1:0] rs;
        @(posedge clk_sys_i);
        s_axi_awaddr  <= ba(i);
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(negedge clk_sys_i);
            at = s_axi_awvalid & s_axi_awready;
            wt = s_axi_wvalid & s_axi_wready;
            bt = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clk_sys_i);
            if (at) s_axi_awvalid <= 1'h0;
            if (wt) s_axi_wvalid <= 1'h0;
        end while (bt !== 1'h1);
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, rs});
    endtask

    task automatic rd(input logic [9:0] i, input logic [31:0] ed,
                      input logic [1:0] er);
        logic at, rt;
        logic [31:0] dt;
        logic [1:0]  rs;
        @(posedge clk_sys_i);
        s_axi_araddr  <= ba(i);
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(negedge clk_sys_i);
            at = s_axi_arvalid & s_axi_arready;
            rt = s_axi_rvalid;
            dt = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk_sys_i);
            if (at) s_axi_arvalid <= 1'h0;
        end while (rt !== 1'h1);
        s_axi_rready <= 1'h0;
        chk("rdata", ed, dt);
        chk("rresp", {30'h0, er}, {30'h0, rs});
    endtask

    // one sample tick; pushes must last exactly one cycle
    task automatic tick();
        @(posedge clk_sys_i);
        sample_tick_i <= 1'h1;
        @(posedge clk_sys_i);
        sample_tick_i <= 1'h0;
        @(negedge clk_sys_i);
        p = fifo_push_o;
        d = data_ready_o;
        @(negedge clk_sys_i);
        chk("push_once", 32'h0, {23'h0, fifo_push_o});
    endtask

    // k=0 external bytes loaded, otherwise arbitration lost
    task automatic strobe(input int k);
        @(posedge clk_sys_i);
        if (k == 0) ext_loaded_i <= 1'h1;
        else arb_lost_i <= 1'h1;
        @(posedge clk_sys_i);
        ext_loaded_i <= 1'h0;
        arb_lost_i   <= 1'h0;
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // hang guard: a few hundred cycles expected, ceiling well above
    // ------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys_i = 1'h0;
        resetn_i <= 1'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '0;
        {s_axi_arvalid, s_axi_rready, sample_tick_i} <= '0;
        s_axi_wstrb <= 4'h1;
        {ext_loaded_i, arb_lost_i, aux_idle_i} <= '0;
        aux_if_enabled_i <= 1'h1;
        n_mismatch = 0;
        total_checks = 0;
        cycles = 0;
        // each register written with a value, then its complement
        rows = '{'{`IDX_WAKE, 32'hffffff00, 32'h0},
                 '{`IDX_WAKE, 32'hffffffff, 32'hff},
                 '{`IDX_FIFO, 32'h000000a5, 32'ha5},
                 '{`IDX_FIFO, 32'hffffff5a, 32'h5a},
                 '{`IDX_MCTL, 32'h000000a5, 32'ha5},
                 '{`IDX_MCTL, 32'h0000005a, 32'h5a},
                 '{`IDX_T0ADDR, 32'h0000006c, 32'h6c},
                 '{`IDX_T0ADDR, 32'h00000093, 32'h93},
                 '{`IDX_T0REG, 32'h000000c3, 32'hc3},
                 '{`IDX_T0REG, 32'h0000003c, 32'h3c},
                 '{`IDX_IRQ_EN, 32'hffffffff, 32'h3},
                 '{`IDX_IRQ_EN, 32'h00000000, 32'h0}};
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'h1;
        // reset values of every register
        foreach (rows[i]) rd(rows[i].idx, 32'h0, `RESP_OKAY);
        rd(`IDX_IRQ_STAT, 32'h0, `RESP_OKAY);
        // table: write, read back, upper bits must read zero
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wval, `RESP_OKAY);
            rd(rows[i].idx, rows[i].rval, `RESP_OKAY);
        end
        chk("wake", 32'hff, {24'h0, motion_wake_level_o});
        chk("stop", 32'h1, {31'h0, stop_between_reads_o});
        chk("div", 32'ha, {28'h0, aux_bus_clk_div_o});
        chk("rnw", 32'h1, {31'h0, target0_read_not_write_o});
        chk("t0addr", 32'h13, {25'h0, target0_bus_addr_o});
        chk("t0reg", 32'h3c, {24'h0, target0_start_reg_o});
        chk("arb_en", 32'h0, {31'h0, arb_detect_en_o});
        // low lane disabled: write ignored but still answered
        s_axi_wstrb <= 4'h0;
        wr(`IDX_WAKE, 32'h0, `RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        rd(`IDX_WAKE, 32'hff, `RESP_OKAY);
        // unmapped place is refused both ways
        wr(10'h000, 32'h55, `RESP_DECERR);
        rd(10'h000, 32'h0, `RESP_DECERR);
        // each fifo source alone; target 3 via master control
        for (int k = 0; k < 9; k++) begin
            wr(`IDX_FIFO, (k < 8) ? (32'h1 << k) : 32'h0, `RESP_OKAY);
            wr(`IDX_MCTL, (k == 8) ? 32'h20 : 32'h0, `RESP_OKAY);
            tick();
            chk("push", (k == 8) ? 32'h100 : (k >= 3) ?
                32'h1 << (7 - k) : 32'h1 << (5 + k),
                {23'h0, p});
        end
        // data ready: immediate, held for external bytes, bypassed
        tick();
        chk("drdy_now", 32'h1, {31'h0, d});
        wr(`IDX_MCTL, 32'h40, `RESP_OKAY);
        tick();
        chk("drdy_held", 32'h0, {31'h0, d});
        tick();
        chk("drdy_held2", 32'h0, {31'h0, d});
        strobe(0);
        @(negedge clk_sys_i);
        chk("drdy_loaded", 32'h1, {31'h0, data_ready_o});
        @(posedge clk_sys_i);
        aux_if_enabled_i <= 1'h0;
        tick();
        chk("drdy_aux_off", 32'h1, {31'h0, d});
        // interrupt: masked, enabled, cleared
        rd(`IDX_IRQ_STAT, 32'h1, `RESP_OKAY);
        chk("irq_masked", 32'h0, {31'h0, irq_o});
        wr(`IDX_IRQ_EN, 32'h1, `RESP_OKAY);
        chk("irq_on", 32'h1, {31'h0, irq_o});
        wr(`IDX_IRQ_CLR, 32'h1, `RESP_OKAY);
        rd(`IDX_IRQ_CLR, 32'h0, `RESP_OKAY);
        rd(`IDX_IRQ_STAT, 32'h0, `RESP_OKAY);
        chk("irq_off", 32'h0, {31'h0, irq_o});
        // arbitration loss ignored unless multi-controller is on
        wr(`IDX_MCTL, 32'h0, `RESP_OKAY);
        strobe(1);
        rd(`IDX_IRQ_STAT, 32'h0, `RESP_OKAY);
        aux_idle_i <= 1'h1;
        @(negedge clk_sys_i);
        chk("gate_idle", 32'h1, {31'h0, aux_clk_gate_en_o});
        wr(`IDX_MCTL, 32'h80, `RESP_OKAY);
        chk("gate_multi", 32'h0, {31'h0, aux_clk_gate_en_o});
        chk("arb_en_on", 32'h1, {31'h0, arb_detect_en_o});
        strobe(1);
        rd(`IDX_IRQ_STAT, 32'h2, `RESP_OKAY);
        wr(`IDX_IRQ_EN, 32'h2, `RESP_OKAY);
        chk("irq_arb", 32'h1, {31'h0, irq_o});
        wr(`IDX_IRQ_CLR, 32'h2, `RESP_OKAY);
        chk("irq_arb_off", 32'h0, {31'h0, irq_o});
        // mid-run reset clears the bank again
        @(posedge clk_sys_i);
        resetn_i <= 1'h0;
        @(posedge clk_sys_i);
        resetn_i <= 1'h1;
        rd(`IDX_MCTL, 32'h0, `RESP_OKAY);
        rd(`IDX_IRQ_EN, 32'h0, `RESP_OKAY);
        chk("gate_rst", 32'h1, {31'h0, aux_clk_gate_en_o});
        test_done();
    end
endmodule
